// ---- src/lin_irq_defines.vh ----
// Register map, field positions and masks of the interrupt-enable block
`ifndef LIN_IRQ_DEFINES_VH
`define LIN_IRQ_DEFINES_VH

`define ADDR_W          8
`define OFS_CONTROL     8'h00
`define OFS_ENABLE_SET  8'h04
`define OFS_ENABLE_CLR  8'h08
`define OFS_STATUS      8'h0c
`define OFS_STATUS_CLR  8'h10

`define CTRL_LIN_MODE   0
`define CONTROL_RESET   1'b0
`define ENABLE_RESET    32'h00000000
`define STATUS_RESET    32'h00000000

`define BIT_BIT_ERR     31
`define BIT_PHYS_BUS    30
`define BIT_CHECKSUM    29
`define BIT_SYNC_FIELD  28
`define BIT_NO_RESP     27
`define BIT_FRAMING     26
`define BIT_OVERRUN     25
`define BIT_PARITY      24
`define BIT_IDENT       13
`define BIT_RX          9
`define BIT_TX          8
`define BIT_TOA3_WAKE   7
`define BIT_TOA_WAKE    6
`define BIT_BUS_TMO     4
`define BIT_WAKEUP      1
`define BIT_BREAK       0

// Implemented fields; all other positions reserved
`define IMPL_MASK       32'hff00_23d3
// Writable in LIN mode only, and effective in LIN mode only
`define LIN_ONLY_MASK   32'hf800_20d0
// Writable in SCI-compatible mode only
`define SCI_ONLY_MASK   32'h0000_0001

`endif

// ---- src/enable_bit_cell.v ----
// One enable bit: write-one-to-set, write-one-to-clear, mode gating
`timescale 1ns/1ns
module enable_bit_cell #(
  parameter IMPL     = 1,
  parameter LIN_ONLY = 0,
  parameter SCI_ONLY = 0
) (
  input  wire mclk,
  input  wire sys_rst,
  input  wire linMode,
  input  wire setWr,
  input  wire clrWr,
  input  wire dataBit,
  output wire stored,
  output wire effective
);

  wire modeOk;
  reg  enable_q;
  reg  enable_d;

  assign modeOk = (LIN_ONLY != 0) ? linMode :
                  (SCI_ONLY != 0) ? ~linMode : 1'b1;

  always @* begin
    enable_d = enable_q;
    if (setWr && dataBit && modeOk) begin
      enable_d = 1'b1;
    end else if (clrWr && dataBit && modeOk) begin
      enable_d = 1'b0;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_q <= 1'b0;
    end else if (IMPL != 0) begin
      enable_q <= enable_d;
    end
  end

  assign stored = (IMPL != 0) ? enable_q : 1'b0;
  // LIN-only takes effect in LIN mode
  assign effective = stored & ((LIN_ONLY != 0) ? linMode : 1'b1);

endmodule // enable_bit_cell

// ---- src/sticky_flag_bank.v ----
// Sticky event flags with write-one-to-clear; a set beats a clear
`timescale 1ns/1ns
module sticky_flag_bank #(
  parameter WIDTH = 32
) (
  input  wire             mclk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] implMask,
  input  wire [WIDTH-1:0] setVec,
  input  wire             clrWr,
  input  wire [WIDTH-1:0] clrVec,
  output wire [WIDTH-1:0] flags
);

  reg  [WIDTH-1:0] flags_q;
  wire [WIDTH-1:0] flags_d;

  assign flags_d = ((flags_q & ~(clrVec & {WIDTH{clrWr}})) | setVec) & implMask;

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= {WIDTH{1'b0}};
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule // sticky_flag_bank

// ---- src/lin_sci_interrupt_enable_set.v ----
// Interrupt-enable set register of the LIN / SCI-compatible serial module
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "lin_irq_defines.vh"
module lin_sci_interrupt_enable_set #(
  parameter ADDR_W = `ADDR_W,
  parameter DATA_W = 32
) (
  input  wire              mclk,
  input  wire              sys_rst,
  input  wire [ADDR_W-1:0] regAddr,
  input  wire [DATA_W-1:0] regWdata,
  input  wire              regWr,
  input  wire              regRd,
  output wire [DATA_W-1:0] regRdata,
  input  wire              protected_write_mode,
  input  wire              bitErrorEvent,
  input  wire              physBusErrorEvent,
  input  wire              checksumErrorEvent,
  input  wire              syncFieldErrorEvent,
  input  wire              noResponseEvent,
  input  wire              framingErrorEvent,
  input  wire              overrunErrorEvent,
  input  wire              parityErrorEvent,
  input  wire              identifierEvent,
  input  wire              rxReadyEvent,
  input  wire              txReadyEvent,
  input  wire              timeoutThreeWakeupsEvent,
  input  wire              timeoutAfterWakeupEvent,
  input  wire              busTimeoutEvent,
  input  wire              wakeupEvent,
  input  wire              breakDetectEvent,
  output wire              serial_lin_module,
  output wire              bit_error_irq_enable,
  output wire              phys_bus_error_irq_enable,
  output wire              checksum_irq_enable,
  output wire              sync_field_error_irq_enable,
  output wire              no_response_irq_enable,
  output wire              framing_error_irq_enable,
  output wire              overrun_irq_enable,
  output wire              parity_irq_enable,
  output wire              identifier_irq_enable,
  output wire              rx_ready_irq_enable,
  output wire              tx_ready_irq_enable,
  output wire              timeout_three_wakeups_irq_enable,
  output wire              timeout_after_wakeup_irq_enable,
  output wire              bus_timeout_irq_enable,
  output wire              wakeup_irq_enable,
  output wire              break_detect_irq_enable,
  output wire              irq
);

  localparam [DATA_W-1:0] IMPL_MASK = `IMPL_MASK;
  localparam [DATA_W-1:0] LIN_MASK  = `LIN_ONLY_MASK;
  localparam [DATA_W-1:0] SCI_MASK  = `SCI_ONLY_MASK;

  reg              linMode_q;
  reg              linMode_d;
  reg [DATA_W-1:0] rdata_q;
  reg [DATA_W-1:0] rdata_d;

  wire             hitControl;
  wire             hitEnableSet;
  wire             hitEnableClr;
  wire             hitStatus;
  wire             hitStatusClr;
  wire             setWr;
  wire             clrWr;
  wire             statusClrWr;
  wire [DATA_W-1:0] enableStored;
  wire [DATA_W-1:0] enableEffective;
  wire [DATA_W-1:0] eventVec;
  wire [DATA_W-1:0] statusFlags;

  // Address decode
  assign hitControl   = (regAddr == `OFS_CONTROL);
  assign hitEnableSet = (regAddr == `OFS_ENABLE_SET);
  assign hitEnableClr = (regAddr == `OFS_ENABLE_CLR);
  assign hitStatus    = (regAddr == `OFS_STATUS);
  assign hitStatusClr = (regAddr == `OFS_STATUS_CLR);

  // writes behave alike in either protection mode
  assign setWr       = regWr & hitEnableSet;
  assign clrWr       = regWr & hitEnableClr;
  assign statusClrWr = regWr & hitStatusClr;

  // Mode control
  always @* begin
    linMode_d = linMode_q;
    if (regWr && hitControl) begin
      linMode_d = regWdata[`CTRL_LIN_MODE];
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      linMode_q <= `CONTROL_RESET;
    end else begin
      linMode_q <= linMode_d;
    end
  end

  assign serial_lin_module = linMode_q;

  // Enable bits, one cell per position
  genvar i;
  generate
    for (i = 0; i < DATA_W; i = i + 1) begin : gEnable
      enable_bit_cell #(
        .IMPL     (IMPL_MASK[i] ? 1 : 0),
        .LIN_ONLY (LIN_MASK[i] ? 1 : 0),
        .SCI_ONLY (SCI_MASK[i] ? 1 : 0)
      ) uCell (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .linMode   (linMode_q),
        .setWr     (setWr),
        .clrWr     (clrWr),
        .dataBit   (regWdata[i]),
        .stored    (enableStored[i]),
        .effective (enableEffective[i])
      );
    end
  endgenerate

  assign bit_error_irq_enable = enableEffective[`BIT_BIT_ERR];

  // physical bus error, LIN mode only
  assign phys_bus_error_irq_enable = enableEffective[`BIT_PHYS_BUS];

  assign checksum_irq_enable = enableEffective[`BIT_CHECKSUM];

  // sync field error, LIN mode only
  assign sync_field_error_irq_enable = enableEffective[`BIT_SYNC_FIELD];

  // No-response error, LIN mode only
  assign no_response_irq_enable = enableEffective[`BIT_NO_RESP];

  assign framing_error_irq_enable = enableEffective[`BIT_FRAMING];

  // Overrun error, both modes
  assign overrun_irq_enable = enableEffective[`BIT_OVERRUN];

  // Parity error, both modes
  assign parity_irq_enable = enableEffective[`BIT_PARITY];

  // Identifier received, LIN mode only
  assign identifier_irq_enable = enableEffective[`BIT_IDENT];

  // Receive ready, both modes
  assign rx_ready_irq_enable = enableEffective[`BIT_RX];

  // Transmit ready, both modes
  assign tx_ready_irq_enable = enableEffective[`BIT_TX];

  // Timeout after three wakeups, LIN mode only
  assign timeout_three_wakeups_irq_enable = enableEffective[`BIT_TOA3_WAKE];

  // Timeout after one wakeup, LIN mode only
  assign timeout_after_wakeup_irq_enable = enableEffective[`BIT_TOA_WAKE];

  // Bus idle timeout, LIN mode only
  assign bus_timeout_irq_enable = enableEffective[`BIT_BUS_TMO];

  // Wakeup, both modes
  assign wakeup_irq_enable = enableEffective[`BIT_WAKEUP];

  // Break detect; only its write is mode-gated
  assign break_detect_irq_enable = enableEffective[`BIT_BREAK];

  // Events laid out in the enable register's positions
  assign eventVec[`BIT_BIT_ERR]    = bitErrorEvent;
  assign eventVec[`BIT_PHYS_BUS]   = physBusErrorEvent;
  assign eventVec[`BIT_CHECKSUM]   = checksumErrorEvent;
  assign eventVec[`BIT_SYNC_FIELD] = syncFieldErrorEvent;
  assign eventVec[`BIT_NO_RESP]    = noResponseEvent;
  assign eventVec[`BIT_FRAMING]    = framingErrorEvent;
  assign eventVec[`BIT_OVERRUN]    = overrunErrorEvent;
  assign eventVec[`BIT_PARITY]     = parityErrorEvent;
  assign eventVec[`BIT_IDENT]      = identifierEvent;
  assign eventVec[`BIT_RX]         = rxReadyEvent;
  assign eventVec[`BIT_TX]         = txReadyEvent;
  assign eventVec[`BIT_TOA3_WAKE]  = timeoutThreeWakeupsEvent;
  assign eventVec[`BIT_TOA_WAKE]   = timeoutAfterWakeupEvent;
  assign eventVec[`BIT_BUS_TMO]    = busTimeoutEvent;
  assign eventVec[`BIT_WAKEUP]     = wakeupEvent;
  assign eventVec[`BIT_BREAK]      = breakDetectEvent;

  // Reserved positions never flag
  assign eventVec[23:14] = 10'h000;
  assign eventVec[12:10] = 3'b000;
  assign eventVec[5]     = 1'b0;
  assign eventVec[3:2]   = 2'b00;

  // Sticky status; a same-cycle event beats the clear

  sticky_flag_bank #(
    .WIDTH (DATA_W)
  ) uStatus (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .implMask (IMPL_MASK),
    .setVec   (eventVec),
    .clrWr    (statusClrWr),
    .clrVec   (regWdata),
    .flags    (statusFlags)
  );

  // Pending sources: a set flag with an effective enable
  wire [DATA_W-1:0] pendingVec;
  assign pendingVec = statusFlags & enableEffective;

  // Level interrupt while any source is pending
  assign irq = |pendingVec;

  // Read data, valid the cycle after the strobe
  always @* begin
    rdata_d = {DATA_W{1'b0}};
    if (regRd) begin
      if (hitEnableSet) begin
        // read back stored enables, any mode
        rdata_d = enableStored;
      end else if (hitControl) begin
        // Mode bit alone; the rest reads zero
        rdata_d[`CTRL_LIN_MODE] = linMode_q;
      end else if (hitStatus) begin
        // Raw sticky flags, whatever the enables
        rdata_d = statusFlags;
      end else begin
        // clear and unmapped addresses read zero
        rdata_d = {DATA_W{1'b0}};
      end
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= {DATA_W{1'b0}};
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;

endmodule // lin_sci_interrupt_enable_set

// ---- testbench/lin_irq_monitor.sv ----
// Assertion checker for the interrupt-enable set register
`timescale 1ns/1ns
`include "lin_irq_defines.vh"
module lin_irq_monitor (
  input wire               mclk,
  input wire               sys_rst,
  input wire [`ADDR_W-1:0] regAddr,
  input wire [31:0]        regWdata,
  input wire               regWr,
  input wire               regRd,
  input wire [31:0]        regRdata,
  input wire               serial_lin_module,
  input wire               bit_error_irq_enable,
  input wire               phys_bus_error_irq_enable,
  input wire               sync_field_error_irq_enable,
  input wire               framing_error_irq_enable,
  input wire               break_detect_irq_enable
);
  wire setWr = regWr && regAddr == `OFS_ENABLE_SET;
  wire rdSet = regRd && regAddr == `OFS_ENABLE_SET;
  wire lin   = serial_lin_module;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_bit_err_set: assert property (setWr && regWdata[31] && lin |=> bit_error_irq_enable)
    else $error("bit error enable not set");
  a_phys_bus_set: assert property (setWr && regWdata[30] && lin |=> phys_bus_error_irq_enable)
    else $error("bus error enable not set");
  a_sync_field_set: assert property (setWr && regWdata[28] && lin |=> sync_field_error_irq_enable)
    else $error("sync field enable not set");
  a_framing_set: assert property (setWr && regWdata[26] |=> framing_error_irq_enable)
    else $error("framing enable not set");
  a_zero_keeps: assert property (setWr && !regWdata[26] |=> $stable(framing_error_irq_enable))
    else $error("zero write changed enable");
  a_lin_gated: assert property (!lin |-> !bit_error_irq_enable)
    else $error("lin-only enable active in sci mode");
  a_break_lin_ignored: assert property (setWr && lin && !break_detect_irq_enable |=> !break_detect_irq_enable)
    else $error("break enable written in lin mode");
  a_reserved_zero: assert property (rdSet |=> regRdata[23:16] == 8'h00)
    else $error("reserved field read nonzero");
  a_read_match: assert property (rdSet |=> regRdata[26] == framing_error_irq_enable)
    else $error("readback differs from enable");
endmodule // lin_irq_monitor

bind lin_sci_interrupt_enable_set lin_irq_monitor mon_u (
  .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .serial_lin_module(serial_lin_module),
  .bit_error_irq_enable(bit_error_irq_enable),
  .phys_bus_error_irq_enable(phys_bus_error_irq_enable),
  .sync_field_error_irq_enable(sync_field_error_irq_enable),
  .framing_error_irq_enable(framing_error_irq_enable),
  .break_detect_irq_enable(break_detect_irq_enable));

// ---- testbench/tb_top.sv ----
// Self-checking bench for the interrupt-enable set register
`timescale 1ns/1ns
`include "lin_irq_defines.vh"
module tb_top;
  logic        mclk = 0, sys_rst = 1, regWr = 0, regRd = 0, protected_write_mode = 0;
  logic [7:0]  regAddr = 0;
  logic [31:0] regWdata = 0, regRdata;
  logic [15:0] ev = 0;
  logic serial_lin_module, bit_error_irq_enable, phys_bus_error_irq_enable, checksum_irq_enable;
  logic sync_field_error_irq_enable, no_response_irq_enable, framing_error_irq_enable;
  logic overrun_irq_enable, parity_irq_enable, identifier_irq_enable, rx_ready_irq_enable;
  logic tx_ready_irq_enable, timeout_three_wakeups_irq_enable, timeout_after_wakeup_irq_enable;
  logic bus_timeout_irq_enable, wakeup_irq_enable, break_detect_irq_enable, irq;
  int   nMismatch = 0, numChecks = 0;
  wire [31:0] enOut;

  // Enable outputs gathered in register positions
  assign enOut = {bit_error_irq_enable, phys_bus_error_irq_enable, checksum_irq_enable,
    sync_field_error_irq_enable, no_response_irq_enable, framing_error_irq_enable,
    overrun_irq_enable, parity_irq_enable, 10'h000, identifier_irq_enable, 3'b000,
    rx_ready_irq_enable, tx_ready_irq_enable, timeout_three_wakeups_irq_enable,
    timeout_after_wakeup_irq_enable, 1'b0, bus_timeout_irq_enable, 2'b00,
    wakeup_irq_enable, break_detect_irq_enable};

  lin_sci_interrupt_enable_set dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .protected_write_mode(protected_write_mode),
    .serial_lin_module(serial_lin_module), .bit_error_irq_enable(bit_error_irq_enable),
    .phys_bus_error_irq_enable(phys_bus_error_irq_enable),
    .checksum_irq_enable(checksum_irq_enable),
    .sync_field_error_irq_enable(sync_field_error_irq_enable),
    .no_response_irq_enable(no_response_irq_enable),
    .framing_error_irq_enable(framing_error_irq_enable),
    .overrun_irq_enable(overrun_irq_enable), .parity_irq_enable(parity_irq_enable),
    .identifier_irq_enable(identifier_irq_enable), .rx_ready_irq_enable(rx_ready_irq_enable),
    .tx_ready_irq_enable(tx_ready_irq_enable),
    .timeout_three_wakeups_irq_enable(timeout_three_wakeups_irq_enable),
    .timeout_after_wakeup_irq_enable(timeout_after_wakeup_irq_enable),
    .bus_timeout_irq_enable(bus_timeout_irq_enable), .wakeup_irq_enable(wakeup_irq_enable),
    .break_detect_irq_enable(break_detect_irq_enable), .irq(irq),
    .bitErrorEvent(ev[15]), .physBusErrorEvent(ev[14]),
    .checksumErrorEvent(ev[13]), .syncFieldErrorEvent(ev[12]), .noResponseEvent(ev[11]),
    .framingErrorEvent(ev[10]), .overrunErrorEvent(ev[9]), .parityErrorEvent(ev[8]),
    .identifierEvent(ev[7]), .rxReadyEvent(ev[6]), .txReadyEvent(ev[5]),
    .timeoutThreeWakeupsEvent(ev[4]), .timeoutAfterWakeupEvent(ev[3]),
    .busTimeoutEvent(ev[2]), .wakeupEvent(ev[1]), .breakDetectEvent(ev[0]));

  always #5 mclk = ~mclk;

  task automatic stopTest;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic doReset;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1;
    chk(what, exp, regRdata);
  endtask

  // LIN mode writes, gating and readback
  task automatic testLinMode;
    rd(`OFS_ENABLE_SET, `ENABLE_RESET, "reset value");
    wr(`OFS_CONTROL, 32'h00000001);
    chk("lin mode out", 1, serial_lin_module);
    rd(`OFS_CONTROL, 32'h00000001, "control read");
    wr(`OFS_ENABLE_SET, 32'h00000001);
    rd(`OFS_ENABLE_SET, 32'h00000000, "break in lin");
    wr(`OFS_ENABLE_SET, 32'hffffffff);
    rd(`OFS_ENABLE_SET, `IMPL_MASK & ~`SCI_ONLY_MASK, "lin set all");
    chk("effective lin", `IMPL_MASK & ~`SCI_ONLY_MASK, enOut);
    chk("bit error en", 1, bit_error_irq_enable);
    chk("bus error en", 1, phys_bus_error_irq_enable);
    chk("checksum en", 1, checksum_irq_enable);
    chk("sync field en", 1, sync_field_error_irq_enable);
    protected_write_mode <= 1'b1;
    rd(`OFS_ENABLE_SET, `IMPL_MASK & ~`SCI_ONLY_MASK, "protected read");
    protected_write_mode <= 1'b0;
    wr(`OFS_CONTROL, 32'h00000000);
    chk("bit error en sci", 0, bit_error_irq_enable);
    chk("framing en sci", 1, framing_error_irq_enable);
    chk("effective sci", `IMPL_MASK & ~`SCI_ONLY_MASK & ~`LIN_ONLY_MASK, enOut);
  endtask

  // SCI mode writes, zero writes and reserved bits
  task automatic testSciMode;
    wr(`OFS_ENABLE_SET, 32'hffffffff);
    rd(`OFS_ENABLE_SET, `IMPL_MASK & ~`LIN_ONLY_MASK, "sci set all");
    chk("effective sci all", `IMPL_MASK & ~`LIN_ONLY_MASK, enOut);
    wr(`OFS_ENABLE_SET, 32'h00000000);
    rd(`OFS_ENABLE_SET, `IMPL_MASK & ~`LIN_ONLY_MASK, "zero write");
    rd(8'h20, 32'h00000000, "unmapped");
  endtask

  // Events raise, enables mask, an event beats a same-cycle status clear
  task automatic testIrq;
    @(posedge mclk);
    ev <= 16'hffff;
    @(posedge mclk);
    ev <= 16'h0000;
    rd(`OFS_STATUS, `IMPL_MASK, "status");
    chk("irq raised", 1, irq);
    wr(`OFS_ENABLE_CLR, 32'hffffffff);
    chk("irq masked", 0, irq);
    @(posedge mclk);
    ev       <= 16'h0001;
    regAddr  <= `OFS_STATUS_CLR;
    regWdata <= 32'hffffffff;
    regWr    <= 1'b1;
    @(posedge mclk);
    ev       <= 16'h0000;
    regWr    <= 1'b0;
    rd(`OFS_STATUS, 32'h00000001, "set beats clear");
    wr(`OFS_STATUS_CLR, 32'hffffffff);
    rd(`OFS_STATUS, 32'h00000000, "status cleared");
  endtask

  initial begin
    #50000;
    nMismatch++;
    stopTest();
  end

  initial begin
    doReset();
    testLinMode();
    doReset();
    rd(`OFS_ENABLE_SET, `ENABLE_RESET, "mid-run reset");
    chk("enables after reset", `ENABLE_RESET, enOut);
    chk("mode after reset", 0, serial_lin_module);
    testSciMode();
    testIrq();
    stopTest();
  end
endmodule // tb_top
